// ==== verilog/sercol_consts.svh ====
// constants of the slave event request collector: offsets, bit positions, reset values
`ifndef SERCOL_CONSTS_SVH
`define SERCOL_CONSTS_SVH

// ======================================
// byte offsets of the registers
`define SERCOL_OFS_MASTER_MASK      16'h0200
`define SERCOL_OFS_HOST_MASK        16'h0204
`define SERCOL_OFS_MASTER_REQ       16'h0210
`define SERCOL_OFS_HOST_REQ         16'h0220
`define SERCOL_OFS_FIRST_SYNC_OUTPUT_STATUS     16'h098E
`define SERCOL_OFS_SECOND_SYNC_OUTPUT_STATUS     16'h098F

// ======================================
// reset values and implemented-bit masks
`define SERCOL_MASTER_MASK_RST      32'h0000_0000
`define SERCOL_HOST_MASK_RST        32'h00FF_FF0F
`define SERCOL_MASTER_REQ_USED      16'h00FD
`define SERCOL_HOST_REQ_USED        32'h0000_0F7F

// ======================================
// configuration bit positions
`define SERCOL_CFG_FIRST_SYNC_OUTPUT_MAP        3
`define SERCOL_CFG_SECOND_SYNC_OUTPUT_MAP        7
`define SERCOL_CFG_EMULATION        8

// ======================================
// sticky flag slots
`define SERCOL_NFLAGS               13
`define SERCOL_F_AL_STATUS          0
`define SERCOL_F_DL_STATUS          1
`define SERCOL_F_M_LATCH            2
`define SERCOL_F_WATCHDOG           3
`define SERCOL_F_EEPROM             4
`define SERCOL_F_SECOND_SYNC_OUTPUT              5
`define SERCOL_F_FIRST_SYNC_OUTPUT              6
`define SERCOL_F_H_LATCH            7
`define SERCOL_F_AL_CTRL            8
`define SERCOL_F_ACT0               9

`endif

// ==== verilog/sercol_pkg.sv ====
// types of the slave event request collector
package sercol_pkg;

  // ======================================
  // one byte-wide register access from either side
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } sercol_acc_t;

  // ======================================
  // registered state of the top module
  typedef struct packed {
    logic [7:0]  m_rdata;
    logic [7:0]  h_rdata;
    logic        irq;
    logic [15:0] evt_field;
  } sercol_state_t;

  // state of one sticky flag
  typedef struct packed {
    logic flag;
  } sercol_flag_t;

  // state of one mask register
  typedef struct packed {
    logic [31:0] value;
  } sercol_mask_t;

endpackage : sercol_pkg

// ==== verilog/sercol_flag.sv ====
// one sticky event flag, set wins over clear
`timescale 1ns/1ps
`default_nettype none

module sercol_flag
  import sercol_pkg::*;
(
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic reset,
  // event and clear
  input  wire logic set,
  input  wire logic clr,
  // flag
  output logic      flag_q
);

  sercol_flag_t s_q;
  sercol_flag_t s_d;

  // ======================================
  // next state: an event in the clearing cycle is kept
  always_comb begin
    s_d = s_q;
    if (set) begin
      s_d.flag = 1'b1;
    end else if (clr) begin
      s_d.flag = 1'b0;
    end
  end

  // state register
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign flag_q = s_q.flag;

endmodule : sercol_flag

`default_nettype wire

// ==== verilog/sercol_mask_reg.sv ====
// byte-writable 32-bit mask register
`timescale 1ns/1ps
`default_nettype none

module sercol_mask_reg
  import sercol_pkg::*;
#(
  parameter logic [31:0] RST_VAL = 32'h0000_0000
)
(
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        reset,
  // byte write
  input  wire logic [3:0]  byte_we,
  input  wire logic [7:0]  wdata,
  // mask value
  output logic      [31:0] value_q
);

  sercol_mask_t s_q;
  sercol_mask_t s_d;

  // ======================================
  // next state: each enabled lane takes the write byte
  always_comb begin
    s_d = s_q;
    for (int i = 0; i < 4; i++) begin
      if (byte_we[i]) begin
        s_d.value[i*8 +: 8] = wdata;
      end
    end
  end

  // state register
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      s_q.value <= RST_VAL;
    end else begin
      s_q <= s_d;
    end
  end

  assign value_q = s_q.value;

endmodule : sercol_mask_reg

`default_nettype wire

// ==== verilog/sercol_top.sv ====
// event request collector of the slave controller: both request registers, masks and host interrupt
// ======================================
// What this block does
// - master request bits 7..4 follow sync channel 3..0 pending status
// - master bit 3 sets on application layer status change, clears on master status read
// - master bit 2 sets on data link status change, clears on master status read
// - master bit 0 sets on latch change, clears after master latch read leaves no event while the master controls the latch
// - multi-byte registers put least significant byte at the lowest address
// - host bits 11..8 show sync channel 3..0 interrupt, bit 0 or 1 of its reg 5h
// - host bit 6 sets on watchdog expiry, clears on watchdog status read
// - host bit 5 shows pending memory command; host acknowledge clears it
// - host bit 4 sets on activation change, clears on reading that activation register
// - host bit 3 shows second sync output if config bit 7; host read of 098F clears
// - host bit 2 shows first sync output if config bit 3; host read of 098E clears
// - host bit 1 sets on latch change, clears after host latch read leaves no event while the host controls the latch
// - host bit 0 sets on control write while emulation off; control read clears
// - host interrupt only for request bits whose host mask bit is 1, reset 00FFFF0F
// - master bits go to frame event field only where master mask is 1, reset 0000
`timescale 1ns/1ps
`default_nettype none
`include "sercol_consts.svh"

module sercol_top
  import sercol_pkg::*;
(
  // clock and reset
  input  wire logic             sys_clk,
  input  wire logic             reset,
  // network master side register access
  input  wire sercol_acc_t      m_acc,
  output logic       [7:0]      m_rdata_q,
  output logic       [15:0]     evt_field_q,
  // host data interface register access
  input  wire sercol_acc_t      h_acc,
  output logic       [7:0]      h_rdata_q,
  output logic                  host_irq_q,
  // sync channel sources
  input  wire logic  [3:0]      sm_status,
  input  wire logic  [3:0][1:0] sm_intr_bits,
  input  wire logic  [3:0]      sm_act_change,
  input  wire logic  [3:0]      h_rd_sm_act,
  // application layer and data link sources
  input  wire logic             al_status_change,
  input  wire logic             m_rd_al_status,
  input  wire logic             dl_status_change,
  input  wire logic             m_rd_dl_status,
  input  wire logic             al_ctrl_write,
  input  wire logic             h_rd_al_ctrl,
  // distributed clock latch and sync sources
  input  wire logic             latch_change,
  input  wire logic             latch_master_ctrl,
  input  wire logic  [1:0]      latch_status,
  input  wire logic             m_rd_latch_time,
  input  wire logic             h_rd_latch_time,
  input  wire logic             first_sync_output,
  input  wire logic             second_sync_output,
  input  wire logic  [8:0]      sync_latch_cfg,
  // watchdog and memory emulation sources
  input  wire logic             wd_pd_expired,
  input  wire logic             h_rd_wd_status,
  input  wire logic             eeprom_cmd,
  input  wire logic             eeprom_ack
);

  sercol_state_t              s_q;
  sercol_state_t              s_d;
  logic [`SERCOL_NFLAGS-1:0]  flag_set;
  logic [`SERCOL_NFLAGS-1:0]  flag_clr;
  logic [`SERCOL_NFLAGS-1:0]  flag_q;
  logic [3:0]                 sm_irq;
  logic [15:0]                m_req;
  logic [31:0]                h_req;
  logic [31:0]                m_mask;
  logic [31:0]                h_mask;
  logic [3:0]                 m_mask_we;
  logic [3:0]                 h_mask_we;
  logic                       latch_empty;

  // ======================================
  // sticky flags, one instance per event source, two for the latch change
  genvar g;
  generate
    for (g = 0; g < `SERCOL_NFLAGS; g++) begin : g_flag
      sercol_flag u_flag (
        .sys_clk (sys_clk),
        .reset   (reset),
        .set     (flag_set[g]),
        .clr     (flag_clr[g]),
        .flag_q  (flag_q[g])
      );
    end
    // per sync channel: interrupt bits and activation-change flags
    for (g = 0; g < 4; g++) begin : g_sm
      assign sm_irq[g] = sm_intr_bits[g][0] | sm_intr_bits[g][1];
      assign flag_set[`SERCOL_F_ACT0 + g] = sm_act_change[g];
      assign flag_clr[`SERCOL_F_ACT0 + g] = h_rd_sm_act[g];
    end
  endgenerate

  // ======================================
  // set and clear conditions of the remaining flags
  assign latch_empty = ~|latch_status;
  assign flag_set[`SERCOL_F_AL_STATUS] = al_status_change;
  assign flag_clr[`SERCOL_F_AL_STATUS] = m_rd_al_status;
  assign flag_set[`SERCOL_F_DL_STATUS] = dl_status_change;
  assign flag_clr[`SERCOL_F_DL_STATUS] = m_rd_dl_status;
  assign flag_set[`SERCOL_F_M_LATCH]   = latch_change;
  assign flag_clr[`SERCOL_F_M_LATCH]   = latch_master_ctrl & m_rd_latch_time & latch_empty;
  assign flag_set[`SERCOL_F_H_LATCH]   = latch_change;
  assign flag_clr[`SERCOL_F_H_LATCH]   = ~latch_master_ctrl & h_rd_latch_time & latch_empty;
  assign flag_set[`SERCOL_F_WATCHDOG]  = wd_pd_expired;
  assign flag_clr[`SERCOL_F_WATCHDOG]  = h_rd_wd_status;
  assign flag_set[`SERCOL_F_EEPROM]    = eeprom_cmd;
  assign flag_clr[`SERCOL_F_EEPROM]    = eeprom_ack;
  assign flag_set[`SERCOL_F_SECOND_SYNC_OUTPUT]     = second_sync_output & sync_latch_cfg[`SERCOL_CFG_SECOND_SYNC_OUTPUT_MAP];
  assign flag_clr[`SERCOL_F_SECOND_SYNC_OUTPUT]     = h_acc.rd & (h_acc.addr == `SERCOL_OFS_SECOND_SYNC_OUTPUT_STATUS);
  assign flag_set[`SERCOL_F_FIRST_SYNC_OUTPUT]     = first_sync_output & sync_latch_cfg[`SERCOL_CFG_FIRST_SYNC_OUTPUT_MAP];
  assign flag_clr[`SERCOL_F_FIRST_SYNC_OUTPUT]     = h_acc.rd & (h_acc.addr == `SERCOL_OFS_FIRST_SYNC_OUTPUT_STATUS);
  assign flag_set[`SERCOL_F_AL_CTRL]   = al_ctrl_write & ~sync_latch_cfg[`SERCOL_CFG_EMULATION];
  assign flag_clr[`SERCOL_F_AL_CTRL]   = h_rd_al_ctrl;

  // ======================================
  // request words; reserved positions stay zero
  always_comb begin
    m_req      = 16'h0000;
    m_req[7:4] = sm_status;
    m_req[3]   = flag_q[`SERCOL_F_AL_STATUS];
    m_req[2]   = flag_q[`SERCOL_F_DL_STATUS];
    m_req[0]   = flag_q[`SERCOL_F_M_LATCH];
    m_req      = m_req & `SERCOL_MASTER_REQ_USED;
    h_req       = 32'h0000_0000;
    h_req[11:8] = sm_irq;
    h_req[6]    = flag_q[`SERCOL_F_WATCHDOG];
    h_req[5]    = flag_q[`SERCOL_F_EEPROM];
    h_req[4]    = |flag_q[`SERCOL_F_ACT0 +: 4];
    h_req[3]    = flag_q[`SERCOL_F_SECOND_SYNC_OUTPUT];
    h_req[2]    = flag_q[`SERCOL_F_FIRST_SYNC_OUTPUT];
    h_req[1]    = flag_q[`SERCOL_F_H_LATCH];
    h_req[0]    = flag_q[`SERCOL_F_AL_CTRL];
    h_req       = h_req & `SERCOL_HOST_REQ_USED;
  end

  // ======================================
  // mask registers: master mask from the master side, host mask from the host side
  always_comb begin
    m_mask_we = 4'h0;
    h_mask_we = 4'h0;
    if (m_acc.wr && (m_acc.addr[15:1] == `SERCOL_OFS_MASTER_MASK >> 1)) begin
      m_mask_we[m_acc.addr[0]] = 1'b1;
    end
    if (h_acc.wr && (h_acc.addr[15:2] == `SERCOL_OFS_HOST_MASK >> 2)) begin
      h_mask_we[h_acc.addr[1:0]] = 1'b1;
    end
  end

  sercol_mask_reg #(
    .RST_VAL (`SERCOL_MASTER_MASK_RST)
  ) u_m_mask (
    .sys_clk (sys_clk),
    .reset   (reset),
    .byte_we (m_mask_we),
    .wdata   (m_acc.wdata),
    .value_q (m_mask)
  );

  sercol_mask_reg #(
    .RST_VAL (`SERCOL_HOST_MASK_RST)
  ) u_h_mask (
    .sys_clk (sys_clk),
    .reset   (reset),
    .byte_we (h_mask_we),
    .wdata   (h_acc.wdata),
    .value_q (h_mask)
  );

  // ======================================
  // byte lane of a word: lane 0 is the lowest address
  function automatic logic [7:0] sercol_lane(input logic [31:0] word, input logic [1:0] lane);
    sercol_lane = word[lane*8 +: 8];
  endfunction : sercol_lane

  // read data mux for one side; unmapped addresses read zero
  function automatic logic [7:0] sercol_read(input logic [15:0] addr, input logic [31:0] mreq,
                                             input logic [31:0] mmask, input logic [31:0] hreq,
                                             input logic [31:0] hmask);
    logic [7:0] d;
    d = 8'h00;
    case (addr[15:2])
      (`SERCOL_OFS_MASTER_MASK >> 2): d = sercol_lane(mmask, addr[1:0]);
      (`SERCOL_OFS_HOST_MASK >> 2):   d = sercol_lane(hmask, addr[1:0]);
      (`SERCOL_OFS_MASTER_REQ >> 2):  d = sercol_lane(mreq, addr[1:0]);
      (`SERCOL_OFS_HOST_REQ >> 2):    d = sercol_lane(hreq, addr[1:0]);
      default:                        d = 8'h00;
    endcase
    sercol_read = d;
  endfunction : sercol_read

  // ======================================
  // next state: read data, frame event field, host interrupt
  always_comb begin
    s_d = s_q;
    if (m_acc.rd) begin
      s_d.m_rdata = sercol_read(m_acc.addr, {16'h0000, m_req}, m_mask, h_req, h_mask);
    end
    if (h_acc.rd) begin
      s_d.h_rdata = sercol_read(h_acc.addr, {16'h0000, m_req}, m_mask, h_req, h_mask);
    end
    s_d.evt_field = m_req & m_mask[15:0];
    s_d.irq       = |(h_req & h_mask);
  end

  // state register
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign m_rdata_q   = s_q.m_rdata;
  assign h_rdata_q   = s_q.h_rdata;
  assign evt_field_q = s_q.evt_field;
  assign host_irq_q  = s_q.irq;

  // ======================================
  // checks
  property p_mirror;
    @(posedge sys_clk) disable iff (reset)
    m_acc.rd && (m_acc.addr == `SERCOL_OFS_MASTER_REQ) |=> m_rdata_q[7:4] == $past(sm_status);
  endproperty
  a_mirror: assert property (p_mirror) else $error("master request does not mirror sync status");

  property p_al_status;
    @(posedge sys_clk) disable iff (reset)
    al_status_change |=> m_req[3] ##1 evt_field_q[3] == $past(m_mask[3]);
  endproperty
  a_al_status: assert property (p_al_status) else $error("status change not flagged");

  property p_dl_clear;
    @(posedge sys_clk) disable iff (reset)
    m_rd_dl_status && !dl_status_change |=> !m_req[2];
  endproperty
  a_dl_clear: assert property (p_dl_clear) else $error("link status flag not cleared");

  property p_m_latch;
    @(posedge sys_clk) disable iff (reset)
    latch_change |=> m_req[0] && h_req[1];
  endproperty
  a_m_latch: assert property (p_m_latch) else $error("latch change not flagged");

  property p_high_byte;
    @(posedge sys_clk) disable iff (reset)
    h_acc.rd && (h_acc.addr == `SERCOL_OFS_HOST_REQ + 16'h0001) |=> h_rdata_q == $past(h_req[15:8]);
  endproperty
  a_high_byte: assert property (p_high_byte) else $error("byte order wrong");

  property p_sm_irq;
    @(posedge sys_clk) disable iff (reset)
    h_req[11:8] == {|sm_intr_bits[3], |sm_intr_bits[2], |sm_intr_bits[1], |sm_intr_bits[0]};
  endproperty
  a_sm_irq: assert property (p_sm_irq) else $error("channel interrupt bits wrong");

  property p_watchdog;
    @(posedge sys_clk) disable iff (reset)
    wd_pd_expired ##1 (!h_rd_wd_status && !wd_pd_expired)[*2] |=> h_req[6];
  endproperty
  a_watchdog: assert property (p_watchdog) else $error("watchdog flag lost");

  property p_eeprom_clr;
    @(posedge sys_clk) disable iff (reset)
    eeprom_ack && !eeprom_cmd |=> !h_req[5];
  endproperty
  a_eeprom_clr: assert property (p_eeprom_clr) else $error("memory command not cleared");

  property p_second_sync_output;
    @(posedge sys_clk) disable iff (reset)
    second_sync_output && sync_latch_cfg[7] |=> h_req[3];
  endproperty
  a_second_sync_output: assert property (p_second_sync_output) else $error("second sync output not shown");

  property p_ctrl_emul;
    @(posedge sys_clk) disable iff (reset)
    !h_req[0] && (!al_ctrl_write || sync_latch_cfg[8]) |=> !h_req[0];
  endproperty
  a_ctrl_emul: assert property (p_ctrl_emul) else $error("control event raised under emulation");

  property p_irq;
    @(posedge sys_clk) disable iff (reset)
    ##1 host_irq_q == |($past(h_req) & $past(h_mask));
  endproperty
  a_irq: assert property (p_irq) else $error("host interrupt does not follow masked requests");

  property p_field;
    @(posedge sys_clk) disable iff (reset)
    ##1 evt_field_q == ($past(m_req) & $past(m_mask[15:0]));
  endproperty
  a_field: assert property (p_field) else $error("frame event field not masked");

endmodule : sercol_top

`default_nettype wire

// ==== bench/sercol_host_model.sv ====
// partner model: host controller and network master issuing byte-wide register accesses
`timescale 1ns/1ps
`default_nettype none

module sercol_host_model
  import sercol_pkg::*;
(
  // clock
  input  wire logic        sys_clk,
  // network master side access
  output var  sercol_acc_t m_acc,
  input  wire logic [7:0]  m_rdata_q,
  // host side access
  output var  sercol_acc_t h_acc,
  input  wire logic [7:0]  h_rdata_q
);
  // ======================================
  // both buses idle from time zero
  initial begin
    m_acc = '0;
    h_acc = '0;
  end

  // one byte access (side 1 = host); held over exactly one taking edge, data taken after it
  task automatic acc(input bit side, input bit wr, input logic [15:0] addr, input logic [7:0] wd,
                     output logic [7:0] rd);
    sercol_acc_t a;
    a = '{rd: !wr, wr: wr, addr: addr, wdata: wd};
    @(negedge sys_clk);
    if (side) begin
      h_acc = a;
    end else begin
      m_acc = a;
    end
    @(posedge sys_clk);
    @(negedge sys_clk);
    m_acc = '0;
    h_acc = '0;
    rd = side ? h_rdata_q : m_rdata_q;
  endtask : acc

  // multi-byte read, lowest address is the least significant byte
  task automatic rdw(input bit side, input logic [15:0] base, input int n, output logic [31:0] v);
    logic [7:0] b;
    v = '0;
    for (int i = 0; i < n; i++) begin
      acc(side, 1'b0, base + 16'(i), 8'h00, b);
      v[8*i +: 8] = b;
    end
  endtask : rdw

  // single byte write
  task automatic wr(input bit side, input logic [15:0] addr, input logic [7:0] data);
    logic [7:0] d;
    acc(side, 1'b1, addr, data, d);
  endtask : wr
endmodule : sercol_host_model
`default_nettype wire

// ==== bench/slave_event_request_collector_bench.sv ====
// self-checking bench of the event request collector
`timescale 1ns/1ps
`default_nettype none
`include "sercol_consts.svh"

module slave_event_request_collector_bench
  import sercol_pkg::*;
;
  // ======================================
  // signals
  logic             sys_clk;
  logic             reset;
  sercol_acc_t      m_acc;
  sercol_acc_t      h_acc;
  logic [7:0]       m_rdata_q;
  logic [7:0]       h_rdata_q;
  logic [15:0]      evt_field_q;
  logic             host_irq_q;
  logic [3:0]       sm_status;
  logic [3:0][1:0]  si;
  logic             latch_master_ctrl;
  logic [1:0]       latch_status;
  logic [1:0]       so;
  logic [8:0]       cfg;
  logic [20:0]      pl;
  int               err_count;
  int               n_compared;

  // ======================================
  // design and partner
  sercol_top u_sercol_top (
    .sys_clk(sys_clk), .reset(reset), .m_acc(m_acc), .m_rdata_q(m_rdata_q), .evt_field_q(evt_field_q),
    .h_acc(h_acc), .h_rdata_q(h_rdata_q), .host_irq_q(host_irq_q), .sm_status(sm_status),
    .sm_intr_bits(si), .sm_act_change(pl[16:13]), .h_rd_sm_act(pl[20:17]),
    .al_status_change(pl[0]), .m_rd_al_status(pl[1]), .dl_status_change(pl[2]), .m_rd_dl_status(pl[3]),
    .al_ctrl_write(pl[4]), .h_rd_al_ctrl(pl[5]), .latch_change(pl[6]), .latch_master_ctrl(latch_master_ctrl),
    .latch_status(latch_status), .m_rd_latch_time(pl[7]), .h_rd_latch_time(pl[8]),
    .first_sync_output(so[0]), .second_sync_output(so[1]), .sync_latch_cfg(cfg),
    .wd_pd_expired(pl[9]), .h_rd_wd_status(pl[10]), .eeprom_cmd(pl[11]), .eeprom_ack(pl[12])
  );
  sercol_host_model u_sercol_host_model (
    .sys_clk(sys_clk), .m_acc(m_acc), .m_rdata_q(m_rdata_q), .h_acc(h_acc), .h_rdata_q(h_rdata_q)
  );

  // ======================================
  // helpers
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("FAIL t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // read n bytes from one side and compare
  task automatic rc(input bit side, input logic [15:0] base, input int n, input logic [31:0] exp);
    logic [31:0] v;
    u_sercol_host_model.rdw(side, base, n, v);
    chk(v, exp);
  endtask : rc

  // one-cycle pulse on the selected event inputs
  task automatic pulse(input logic [20:0] m);
    @(negedge sys_clk);
    pl = m;
    @(negedge sys_clk);
    pl = '0;
  endtask : pulse

  task automatic finish_test;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : finish_test

  // ======================================
  // scenarios
  task automatic t_reset;
    rc(1, `SERCOL_OFS_HOST_MASK, 4, `SERCOL_HOST_MASK_RST);
    rc(0, `SERCOL_OFS_MASTER_MASK, 2, 0);
    rc(1, `SERCOL_OFS_HOST_REQ, 4, 0);
    rc(0, `SERCOL_OFS_MASTER_REQ, 4, 0);
    chk(host_irq_q, 0);
  endtask : t_reset

  task automatic t_master;
    sm_status = 4'b1001;
    rc(0, `SERCOL_OFS_MASTER_REQ, 4, 32'h90);
    chk(evt_field_q, 0);
    u_sercol_host_model.wr(1, `SERCOL_OFS_MASTER_MASK, 8'hFF);
    rc(0, `SERCOL_OFS_MASTER_MASK, 2, 0);
    u_sercol_host_model.wr(0, `SERCOL_OFS_MASTER_MASK, 8'hF0);
    u_sercol_host_model.wr(0, `SERCOL_OFS_MASTER_MASK + 16'h1, 8'hFF);
    rc(1, `SERCOL_OFS_MASTER_MASK, 2, 32'hFFF0);
    chk(evt_field_q, 32'h90);
    sm_status = 4'b0110;
    rc(1, `SERCOL_OFS_MASTER_REQ, 1, 32'h60);
    sm_status = 4'b0000;
    rc(0, `SERCOL_OFS_MASTER_REQ, 1, 0);
  endtask : t_master

  task automatic t_master_flags;
    latch_master_ctrl = 1'b1;
    latch_status = 2'b01;
    pulse(21'h45);
    rc(0, `SERCOL_OFS_MASTER_REQ, 2, 32'h0D);
    pulse(21'h3);
    rc(0, `SERCOL_OFS_MASTER_REQ, 1, 32'h0D);
    pulse(21'h2);
    rc(0, `SERCOL_OFS_MASTER_REQ, 1, 32'h05);
    pulse(21'h8);
    rc(0, `SERCOL_OFS_MASTER_REQ, 1, 32'h01);
    pulse(21'h80);
    rc(0, `SERCOL_OFS_MASTER_REQ, 1, 32'h01);
    latch_status = 2'b00;
    pulse(21'h100);
    rc(1, `SERCOL_OFS_HOST_REQ, 1, 32'h02);
    chk(host_irq_q, 1);
    pulse(21'h80);
    rc(0, `SERCOL_OFS_MASTER_REQ, 1, 0);
    latch_master_ctrl = 1'b0;
    pulse(21'h100);
    rc(1, `SERCOL_OFS_HOST_REQ, 1, 0);
    chk(host_irq_q, 0);
  endtask : t_master_flags

  task automatic t_host;
    si[2] = 2'b10;
    si[0] = 2'b01;
    rc(1, `SERCOL_OFS_HOST_REQ + 16'h1, 1, 32'h05);
    si = '0;
    rc(1, `SERCOL_OFS_HOST_REQ + 16'h1, 1, 0);
    pulse(21'h200);
    @(negedge sys_clk);
    chk(host_irq_q, 0);
    rc(1, `SERCOL_OFS_HOST_REQ, 1, 32'h40);
    u_sercol_host_model.wr(1, `SERCOL_OFS_HOST_MASK, 8'hFF);
    repeat (2) @(negedge sys_clk);
    chk(host_irq_q, 1);
    pulse(21'h400);
    rc(1, `SERCOL_OFS_HOST_REQ, 1, 0);
    chk(host_irq_q, 0);
    pulse(21'h800);
    rc(1, `SERCOL_OFS_HOST_REQ, 1, 32'h20);
    pulse(21'h1000);
    rc(1, `SERCOL_OFS_HOST_REQ, 1, 0);
    pulse(21'h0A000);
    rc(1, `SERCOL_OFS_HOST_REQ, 1, 32'h10);
    pulse(21'h20000);
    rc(1, `SERCOL_OFS_HOST_REQ, 1, 32'h10);
    pulse(21'h80000);
    rc(1, `SERCOL_OFS_HOST_REQ, 1, 0);
    for (int i = 0; i < 2; i++) begin
      so[i] = 1'b1;
      rc(1, `SERCOL_OFS_HOST_REQ, 1, 0);
      cfg[3 + 4 * i] = 1'b1;
      @(negedge sys_clk);
      so[i] = 1'b0;
      rc(1, `SERCOL_OFS_HOST_REQ, 1, 32'h04 << i);
      rc(0, `SERCOL_OFS_FIRST_SYNC_OUTPUT_STATUS + 16'(i), 1, 0);
      rc(1, `SERCOL_OFS_HOST_REQ, 1, 32'h04 << i);
      rc(1, `SERCOL_OFS_FIRST_SYNC_OUTPUT_STATUS + 16'(i), 1, 0);
      rc(1, `SERCOL_OFS_HOST_REQ, 1, 0);
      cfg[3 + 4 * i] = 1'b0;
    end
    cfg[8] = 1'b1;
    pulse(21'h10);
    rc(1, `SERCOL_OFS_HOST_REQ, 1, 0);
    cfg[8] = 1'b0;
    pulse(21'h10);
    rc(1, `SERCOL_OFS_HOST_REQ, 4, 32'h01);
    pulse(21'h20);
    rc(1, `SERCOL_OFS_HOST_REQ, 1, 0);
  endtask : t_host

  // ======================================
  // hang guard
  initial begin
    repeat (20000) @(posedge sys_clk);
    err_count++;
    finish_test();
  end

  // ======================================
  // main sequence
  initial begin
    err_count = 0;
    n_compared = 0;
    reset = 1'b1;
    sm_status = '0;
    si = '0;
    latch_master_ctrl = 1'b0;
    latch_status = '0;
    so = '0;
    cfg = '0;
    pl = '0;
    repeat (3) @(negedge sys_clk);
    reset = 1'b0;
    t_reset();
    t_master();
    t_master_flags();
    t_host();
    finish_test();
  end
endmodule : slave_event_request_collector_bench
`default_nettype wire
